// ==== bench/cog_clk_src.sv ====
// upstream clock source model for the output gate control bench
// assumes the bench starts and stops it through run
`timescale 1ns/1ps

module cog_clk_src #(
    parameter int HALF_NS = 20
) (
    input wire logic run,
    output logic in_clk
);
    initial in_clk = 1'b0;
    // a stopped source parks static, the failed-input case the block holds
    always begin
        #(HALF_NS);
        if (run) begin
            in_clk = ~in_clk;
        end
    end
endmodule

// ==== bench/test_clock_output_gate_control.sv ====
// self-checking bench for the clock output gate control block
// assumes in_clk half period of four system clocks
`timescale 1ns/1ps

module test_clock_output_gate_control;
    import cog_pkg::*;
    localparam int N = COG_N_OUT;
    // six in_clk periods of eight clocks plus pin sync and output lag
    localparam int SETTLE = 6 * 8 + 6;
    localparam logic [N-1:0] ZERO = '0;
    logic clock, arst_n, in_clk, loss, run, mon_on, seen, moved;
    cog_pad_s mr, gate;
    logic [N-1:0] q_true, q_comp;
    int n_errors, cmp_count, hi_len;

    initial clock = 1'b0;
    always #2.5 clock = ~clock;

    cog_clk_src #(.HALF_NS(20)) src (.run(run), .in_clk(in_clk));
    cog_top uut (.clock(clock), .arst_n(arst_n), .in_clk(in_clk),
        .input_loss_hold(loss), .master_reset_n(mr), .output_gate(gate),
        .q_true(q_true), .q_comp(q_comp));

    // ------------------------------------------------------------
    // compares and helpers
    // ------------------------------------------------------------
    task automatic check(input logic [N-1:0] got, exp, input string msg);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t %s", $time, msg);
        end
    endtask

    task automatic check_bit(input logic got, exp, input string msg);
        check({{(N-1){1'b0}}, got}, {{(N-1){1'b0}}, exp}, msg);
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    // watch n cycles: did outputs ever go high, did they ever change
    task automatic watch(input int n);
        logic [N-1:0] prev;
        prev = q_true;
        seen = 1'b0;
        moved = 1'b0;
        repeat (n) begin
            step(1);
            check(q_comp, ~q_true, "complement pair broken");
            if (q_true !== ZERO) seen = 1'b1;
            if (q_true !== prev) moved = 1'b1;
            prev = q_true;
        end
    endtask

    // a gated edge must never clip a high phase to a runt
    always @(posedge clock) begin
        if (q_true[0] === 1'b1) begin
            hi_len++;
        end else begin
            if (mon_on && hi_len > 0) check_bit(hi_len >= 3, 1'b1, "runt");
            hi_len = 0;
        end
    end

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset_pin();
        mon_on = 1'b0;
        // drop the pin in a high phase so only an async path can clear it
        repeat (8) if (q_true[0] !== 1'b1) step(1);
        check_bit(q_true[0], 1'b1, "no clock before reset");
        mr = '{1'b0, 1'b1};
        #0.5;
        check(q_true, ZERO, "reset true");
        check(q_comp, ~ZERO, "reset comp");
        watch(40);
        check_bit(seen, 1'b0, "reset released early");
        mr = '{1'b1, 1'b1};
        watch(40);
        check_bit(seen, 1'b1, "no clock after reset");
        mon_on = 1'b1;
        $display("test reset_pin done");
    endtask

    task automatic t_gate();
        gate = '{1'b0, 1'b1};
        step(SETTLE);
        watch(40);
        check_bit(seen, 1'b0, "gate low not applied");
        gate = '{1'b1, 1'b1};
        step(SETTLE);
        watch(40);
        check_bit(seen, 1'b1, "gate high not applied");
        $display("test gate done");
    endtask

    task automatic t_open_pads();
        mr = '{1'b0, 1'b0};
        gate = '{1'b0, 1'b0};
        step(SETTLE);
        watch(40);
        check_bit(seen, 1'b1, "open pads not high");
        mr = '{1'b1, 1'b1};
        gate = '{1'b1, 1'b1};
        $display("test open_pads done");
    endtask

    task automatic t_loss(input logic hold);
        loss = hold;
        step(3);
        run = 1'b0;
        step(12);
        watch(60);
        check_bit(moved, 1'b0, "outputs not held");
        loss = 1'b0;
        run = 1'b1;
        watch(60);
        check_bit(seen, 1'b1, "no recovery");
        $display("test loss hold=%0b done", hold);
    endtask

    // ------------------------------------------------------------
    // sequence, watchdog and verdict
    // ------------------------------------------------------------
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    initial begin
        #20000;
        n_errors++;
        conclude();
    end

    initial begin
        arst_n = 1'b0;
        mr = '{1'b1, 1'b1};
        gate = '{1'b1, 1'b1};
        loss = 1'b0;
        run = 1'b1;
        mon_on = 1'b0;
        n_errors = 0;
        cmp_count = 0;
        hi_len = 0;
        repeat (8) @(posedge clock);
        #1 arst_n = 1'b1;
        step(SETTLE);
        mon_on = 1'b1;
        t_reset_pin();
        t_gate();
        t_open_pads();
        t_loss(1'b1);
        t_loss(1'b0);
        conclude();
    end
endmodule

// ==== hdl/cog_sync.sv ====
// multi-bit level synchroniser, one chain per bit
// assumes every bit is a slow level or an oversampled waveform
`timescale 1ns/1ps

module cog_sync
    import cog_pkg::*;
#(
    parameter int WIDTH = COG_PIN_W,
    parameter int STAGES = COG_SYNC_STAGES
) (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);

    typedef struct packed {
        logic [STAGES-1:0][WIDTH-1:0] ff;
    } cog_sync_s;

    cog_sync_s st;
    cog_sync_s next_st;

    // first stage feeds only the next stage
    always_comb begin
        next_st = st;
        next_st.ff[0] = d;
        for (int i = 1; i < STAGES; i++) begin
            next_st.ff[i] = st.ff[i-1];
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign q = st.ff[STAGES-1];

endmodule

// ==== hdl/cog_top.sv ====
// clock output gate control: reset, gated enable and loss hold
// assumes clock oversamples the incoming clock; pins are asynchronous
`timescale 1ns/1ps

// Function
// [RL1] hold outputs latched when input amplitude lost
// [RL2] dead input clock gives stable defined outputs
// [RL3] reset low: true outputs low, complements high
// [RL4] keep reset polarity until reset returns high
// [RL5] open reset and gate pins read high
// [RL6] gate low forces reset polarity, high passes clock
// [RL7] gate takes effect after two to six edges
// [RL8] gate changes only in clock low phase
module cog_top
    import cog_pkg::*;
#(
    parameter int N_OUT = COG_N_OUT,
    parameter int GATE_STAGES = COG_GATE_STAGES
) (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic in_clk,
    input wire logic input_loss_hold,
    input wire cog_pad_s master_reset_n,
    input wire cog_pad_s output_gate,
    output logic [N_OUT-1:0] q_true,
    output logic [N_OUT-1:0] q_comp
);

    // ------------------------------------------------------------
    // pad pull-ups
    // ------------------------------------------------------------
    logic mr_eff;
    logic gate_eff;

    // an undriven pad falls back to its pull-up level
    function automatic logic pad_level(input cog_pad_s p);
        return p.driven ? p.level : 1'b1;
    endfunction

    assign mr_eff = pad_level(master_reset_n); // RL5
    assign gate_eff = pad_level(output_gate); // RL5

    // ------------------------------------------------------------
    // synchronisers
    // ------------------------------------------------------------
    cog_pins_s raw;
    cog_pins_s syn;

    always_comb begin
        raw.in_clk = in_clk;
        raw.input_loss_hold = input_loss_hold;
        raw.output_gate = gate_eff;
        raw.master_reset_n = mr_eff;
    end

    cog_sync #(
        .WIDTH(COG_PIN_W),
        .STAGES(COG_SYNC_STAGES)
    ) u_sync (
        .clock(clock),
        .arst_n(arst_n),
        .d(raw),
        .q(syn)
    );

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic clk_prev;
        logic [GATE_STAGES-1:0] chain;
        logic gate_applied;
        logic out_level;
        logic [COG_LAG_W-1:0] lag;
    } cog_state_s;

    cog_state_s st;
    cog_state_s next_st;
    logic clk_rise;

    assign clk_rise = syn.in_clk && !st.clk_prev;

    always_comb begin
        next_st = st;
        // edge history keeps tracking so a hold release cannot fake a rise
        next_st.clk_prev = syn.in_clk;
        // hold freezes gate and output so a dying input cannot toggle them
        if (!syn.input_loss_hold) begin // RL1 RL2
            // gate chain advances on incoming clock rising edges
            if (clk_rise) begin
                next_st.chain[0] = syn.output_gate; // RL7
                for (int i = 1; i < GATE_STAGES; i++) begin
                    next_st.chain[i] = st.chain[i-1]; // RL7
                end
            end
            // apply only while the clock is low: no shortened pulse
            if (!syn.in_clk) begin
                next_st.gate_applied = st.chain[GATE_STAGES-1]; // RL8
            end
            if (!syn.master_reset_n) begin
                next_st.out_level = 1'b0; // RL4
            end else begin
                // rise only on a fresh edge: no runt after reset or hold
                next_st.out_level = next_st.gate_applied && syn.in_clk &&
                    (clk_rise || st.out_level); // RL6
            end
        end
        // helper: edges seen while gate pin and applied gate differ
        if (syn.output_gate == next_st.gate_applied) begin
            next_st.lag = COG_LAG_ZERO;
        end else if (clk_rise && !syn.input_loss_hold &&
            st.lag != COG_LAG_SAT) begin
            next_st.lag = st.lag + COG_LAG_ONE;
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // the reset pin bypasses all flops so it acts without any edge
    always_comb begin
        for (int i = 0; i < N_OUT; i++) begin
            q_true[i] = st.out_level && mr_eff; // RL3
            q_comp[i] = !(st.out_level && mr_eff); // RL3
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    localparam logic [COG_LAG_W-1:0] LAG_MIN = COG_LAG_W'(COG_GATE_MIN_EDGES);
    localparam logic [COG_LAG_W-1:0] LAG_MAX = COG_LAG_W'(COG_GATE_MAX_EDGES);

    sequence s_gate_moved;
        $changed(st.gate_applied);
    endsequence

    sequence s_reset_seen;
        !syn.master_reset_n ##1 1'b1;
    endsequence

    property p_rl1;
        @(posedge clock) disable iff (!arst_n)
        syn.input_loss_hold |=> $stable(st.out_level);
    endproperty
    a_rl1: assert property (p_rl1) // RL1
        else $error("outputs moved while input loss hold");

    property p_rl2;
        @(posedge clock) disable iff (!arst_n)
        $changed(st.out_level) |-> !$past(syn.input_loss_hold);
    endproperty
    a_rl2: assert property (p_rl2) // RL2
        else $error("output toggled with dead input clock");

    property p_rl3;
        @(posedge clock) disable iff (!arst_n)
        !mr_eff |-> (q_true == '0) && (q_comp == '1);
    endproperty
    a_rl3: assert property (p_rl3) // RL3
        else $error("outputs not in reset polarity");

    property p_rl4;
        @(posedge clock) disable iff (!arst_n)
        s_reset_seen |-> !st.out_level;
    endproperty
    a_rl4: assert property (p_rl4) // RL4
        else $error("output released during reset");

    property p_rl5;
        @(posedge clock) disable iff (!arst_n)
        (!master_reset_n.driven |-> mr_eff) and
        (!output_gate.driven |-> gate_eff);
    endproperty
    a_rl5: assert property (p_rl5) // RL5
        else $error("open pad not read as high");

    property p_rl6;
        @(posedge clock) disable iff (!arst_n)
        !st.gate_applied |-> !st.out_level && (q_comp == '1);
    endproperty
    a_rl6: assert property (p_rl6) // RL6
        else $error("gated output carries clock");

    property p_rl7;
        @(posedge clock) disable iff (!arst_n)
        (st.lag <= LAG_MAX) and
        (s_gate_moved |-> $past(st.lag) >= LAG_MIN);
    endproperty
    a_rl7: assert property (p_rl7) // RL7
        else $error("gate delay outside two to six edges");

    property p_rl8;
        @(posedge clock) disable iff (!arst_n)
        s_gate_moved |-> !$past(syn.in_clk);
    endproperty
    a_rl8: assert property (p_rl8) // RL8
        else $error("gate changed in clock high phase");

endmodule

// ==== inc/cog_pkg.sv ====
// package for the clock output gate control block
// assumes one system clock that oversamples the incoming clock waveform

package cog_pkg;

    // ------------------------------------------------------------
    // sizes and counts
    // ------------------------------------------------------------
    localparam int COG_N_OUT = 15;
    localparam int COG_SYNC_STAGES = 2;
    localparam int COG_GATE_STAGES = 2;
    localparam int COG_GATE_MIN_EDGES = 2;
    localparam int COG_GATE_MAX_EDGES = 6;
    localparam int COG_LAG_W = 3;
    localparam int COG_CLOCK_MHZ = 200;

    // ------------------------------------------------------------
    // pin bundle, raw then synchronised
    // ------------------------------------------------------------
    localparam int COG_PIN_W = 4;
    localparam int COG_PIN_CLK = 0;
    localparam int COG_PIN_LOSS = 1;
    localparam int COG_PIN_GATE = 2;
    localparam int COG_PIN_MR = 3;

    typedef struct packed {
        logic master_reset_n;
        logic output_gate;
        logic input_loss_hold;
        logic in_clk;
    } cog_pins_s;

    // levels presented to a pad that may be left open
    typedef struct packed {
        logic level;
        logic driven;
    } cog_pad_s;

    typedef struct packed {
        logic [COG_N_OUT-1:0] q_true;
        logic [COG_N_OUT-1:0] q_comp;
    } cog_out_s;

    localparam logic [COG_LAG_W-1:0] COG_LAG_ZERO = 3'h0;
    localparam logic [COG_LAG_W-1:0] COG_LAG_ONE = 3'h1;
    localparam logic [COG_LAG_W-1:0] COG_LAG_SAT = 3'h7;

endpackage
